// >>> design/aiq_pkg.sv
package aiq_pkg;
  // 25 ns timer tick from the 100 ns system clock: one tick is a fraction of a cycle,
  // so timers count ticks and advance by ticks-per-cycle each clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 25;
  localparam logic [31:0] TICKS_PER_CLK = 32'(CLK_PERIOD_NS / TICK_NS);
  // classic fixed intra-sample spacing
  localparam int CLASSIC_GAP_NS = 5000;
  localparam logic [31:0] CLASSIC_GAP_CYC = 32'(CLASSIC_GAP_NS / CLK_PERIOD_NS);
  // programmable burst spacing is this base plus register value in ticks
  localparam logic [31:0] BURST_BASE_TICKS = 32'(CLASSIC_GAP_NS / TICK_NS);
  // midscale code for a zero difference in bipolar straight binary
  localparam logic [15:0] MIDSCALE = 16'h8000;
  localparam int NUM_SE_CH = 16;
  localparam int NUM_DIFF_CH = 8;
  localparam int NUM_SRC = 13;
  // sample event sources
  localparam logic [3:0] SRC_FRAME_TIMER = 4'h0;
  localparam logic [3:0] SRC_SOFTWARE = 4'h1;
  localparam logic [3:0] SRC_EXT_DIN = 4'h2;
  // trigger sources (start and stop fields share the coding)
  localparam logic [3:0] TRG_NONE = 4'h0;
  localparam logic [3:0] TRG_SOFTWARE = 4'h1;
  localparam logic [3:0] TRG_EXT = 4'h2;
  localparam logic [3:0] TRG_FRAME_MAX = 4'h3;
  // acquisition modes
  typedef enum logic [1:0] {
    AIQ_MODE_SIMPLE,
    AIQ_MODE_CLASSIC_BURST,
    AIQ_MODE_BURST,
    AIQ_MODE_NSAMPLE
  } aiq_mode_t;
  localparam logic [15:0] RST_CODE = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : aiq_pkg

// >>> design/aiq_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
// free interval timer in 25 ns ticks; tick pulses when the count reaches the period
module aiq_interval_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic run,
  input wire logic [31:0] period_ticks,
  output logic tick
);
  import aiq_pkg::*;
  typedef struct packed {
    logic [32:0] acc;
    logic tick;
  } aiq_tmr_t;
  aiq_tmr_t s_q, s_d;
  logic [32:0] nxt;

  // advance by ticks-per-cycle; remainder carries so the mean rate stays exact
  always_comb begin
    s_d = s_q;
    nxt = s_q.acc + {1'b0, TICKS_PER_CLK};
    s_d.tick = 1'b0;
    if (restart || !run) begin
      s_d.acc = '0;
    end else if (nxt >= {1'b0, period_ticks}) begin
      s_d.acc = nxt - {1'b0, period_ticks};
      s_d.tick = 1'b1;
    end else begin
      s_d.acc = nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : aiq_interval_timer
`default_nettype wire

// >>> design/aiq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - polarity bit plus gain code pick range
// - differential converts high minus low, midscale zero
// - differential mode gives eight paired channels
// - frame and burst timers: 32-bit, 25 ns
// - frame source: internal timer or external pulse
// - start and stop triggers, internal or external
// - thirteen selectable sample event sources
// - simple mode: one sample per event
// - classic modes count and pace samples
// - gate bit plus two-bit source select
// - burst: each strobe scans first to last
// - classic burst spacing fixed five microseconds
// - classic scan period is larger of two
// - burst spacing five microseconds upward, 25 ns
// - frame timer between frames, burst timer within
// - start/stop mode samples between triggers, re-arms
// - n-sample mode stops at frame maximum when a start trigger is set
// - four-bit start and stop source fields
// - optional delay from start to first sample
// - sync bits restart frame timer and counter
module aiq_sequencer #(
  parameter int CH_W = 4,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire aiq_pkg::aiq_mode_t acq_mode,
  input wire logic unipolar_select,
  input wire logic gain_code_high,
  input wire logic gain_code_low,
  input wire logic differential_mode,
  input wire logic [CH_W-1:0] first_channel,
  input wire logic [CH_W-1:0] last_channel,
  input wire logic [3:0] sample_event_select,
  input wire logic [aiq_pkg::NUM_SRC-1:0] sample_event_sources,
  input wire logic sample_gate_control,
  input wire logic [1:0] sample_source_select,
  input wire logic ext_gate_pin,
  input wire logic software_strobe,
  input wire logic frame_sync_pin,
  input wire logic [31:0] frame_timer_ticks,
  input wire logic [31:0] burst_timer_ticks,
  input wire logic [31:0] frame_max,
  input wire logic [31:0] trigger_delay_cycles,
  input wire logic [3:0] trigger_start_source,
  input wire logic [3:0] trigger_stop_source,
  input wire logic ext_trigger_pin,
  input wire logic software_trigger,
  input wire logic sync_frame_timer_on_start,
  input wire logic sync_frame_counter_on_start,
  input wire logic conv_done,
  input wire logic [DATA_W-1:0] conv_data,
  output logic [CH_W-1:0] mux_high_sel,
  output logic [CH_W-1:0] mux_low_sel,
  output logic mux_diff_en,
  output logic [1:0] pga_gain,
  output logic pga_unipolar,
  output logic conv_start,
  output logic sample_valid,
  output logic [DATA_W-1:0] sample_data,
  output logic [CH_W-1:0] sample_channel,
  output logic acquiring,
  output logic frame_done,
  output logic [31:0] frame_count,
  output logic [1:0] range_code_out
);
  import aiq_pkg::*;

  typedef enum logic [2:0] {
    AIQ_IDLE,
    AIQ_DELAY,
    AIQ_WAIT_EVT,
    AIQ_CONVERT,
    AIQ_GAP
  } aiq_state_t;

  typedef struct packed {
    aiq_state_t st;
    logic [1:0] ext_trg_s;
    logic [1:0] sync_s;
    logic [1:0] gate_s;
    logic trg_prev;
    logic sync_prev;
    logic armed;
    logic [31:0] dly;
    logic [32:0] gap;
    logic [31:0] fcnt;
    logic [CH_W-1:0] ch;
    logic [CH_W-1:0] mux_h;
    logic [CH_W-1:0] mux_l;
    logic diff;
    logic [1:0] gain;
    logic unip;
    logic cstart;
    logic sval;
    logic [DATA_W-1:0] sdat;
    logic [CH_W-1:0] sch;
    logic acq;
    logic fdone;
    logic [1:0] range;
  } aiq_state_vec_t;

  aiq_state_vec_t s_q, s_d;
  logic frame_tick;
  logic sync_restart;
  logic ext_trg_rise;
  logic sync_rise;
  logic start_evt;
  logic stop_evt;
  logic sample_evt;
  logic gate_ok;
  logic burst_mode;
  logic classic;
  logic last_in_scan;
  logic [CH_W-1:0] ch_limit;
  logic [32:0] spacing_ticks;

  // trigger source decode shared by start and stop fields
  function automatic logic trig_hit(input logic [3:0] sel, input logic sw,
                                    input logic ext, input logic fmax);
    case (sel)
      TRG_SOFTWARE: trig_hit = sw;
      TRG_EXT: trig_hit = ext;
      TRG_FRAME_MAX: trig_hit = fmax;
      default: trig_hit = 1'b0;
    endcase
  endfunction : trig_hit

  // synchronised pins feed edge detectors only from the second stage
  assign ext_trg_rise = s_q.ext_trg_s[1] && !s_q.trg_prev;
  assign sync_rise = s_q.sync_s[1] && !s_q.sync_prev;
  assign classic = (acq_mode == AIQ_MODE_SIMPLE) || (acq_mode == AIQ_MODE_CLASSIC_BURST);
  assign burst_mode = (acq_mode != AIQ_MODE_SIMPLE);
  // eight channels when inputs pair high and low
  assign ch_limit = differential_mode ? CH_W'(NUM_DIFF_CH - 1) : CH_W'(NUM_SE_CH - 1);
  assign last_in_scan = !burst_mode || (s_q.ch >= last_channel) || (s_q.ch >= ch_limit);
  // start-to-start spacing in ticks: classic is the fixed base, burst adds the timer value
  assign spacing_ticks = (acq_mode == AIQ_MODE_CLASSIC_BURST) ? {1'b0, BURST_BASE_TICKS}
                       : {1'b0, BURST_BASE_TICKS} + {1'b0, burst_timer_ticks};

  // gate: 00 free, 01 gated by pin high, 10 gated by pin low, 11 held off
  always_comb begin
    case (sample_source_select)
      2'b00: gate_ok = 1'b1;
      2'b01: gate_ok = s_q.gate_s[1];
      2'b10: gate_ok = !s_q.gate_s[1];
      default: gate_ok = 1'b0;
    endcase
    if (!sample_gate_control) begin
      gate_ok = 1'b1;
    end
  end

  // start/stop decode; frame maximum reached counts as a stop event in n-sample mode only
  assign start_evt = trig_hit(trigger_start_source, software_trigger, ext_trg_rise, 1'b0);
  assign stop_evt = trig_hit(trigger_stop_source, software_trigger, ext_trg_rise, 1'b0)
                  || ((acq_mode == AIQ_MODE_NSAMPLE) && (frame_max != RST_WORD)
                      && (s_q.fcnt >= frame_max));
  assign sync_restart = start_evt && !s_q.acq && sync_frame_timer_on_start;

  // event source: frame timer, software, external pulse, or one of the others
  always_comb begin
    case (sample_event_select)
      SRC_FRAME_TIMER: sample_evt = frame_tick;
      SRC_SOFTWARE: sample_evt = software_strobe;
      SRC_EXT_DIN: sample_evt = sync_rise;
      default: sample_evt = (sample_event_select < 4'(NUM_SRC))
                          && sample_event_sources[sample_event_select];
    endcase
  end

  // frame pacing timer; in classic modes it paces each scan
  aiq_interval_timer u_frame_timer (
    .clk(clk),
    .rst_n(rst_n),
    .restart(sync_restart),
    .run(s_q.acq),
    .period_ticks(frame_timer_ticks + 32'h0000_0001),
    .tick(frame_tick)
  );

  // sequencer: trigger, delay, event, scan with spacing, store in order
  always_comb begin
    s_d = s_q;
    s_d.ext_trg_s = {s_q.ext_trg_s[0], ext_trigger_pin};
    s_d.sync_s = {s_q.sync_s[0], frame_sync_pin};
    s_d.gate_s = {s_q.gate_s[0], ext_gate_pin};
    s_d.trg_prev = s_q.ext_trg_s[1];
    s_d.sync_prev = s_q.sync_s[1];
    s_d.cstart = 1'b0;
    s_d.sval = 1'b0;
    s_d.fdone = 1'b0;
    s_d.gain = {gain_code_high, gain_code_low};
    s_d.unip = unipolar_select;
    s_d.range = {gain_code_high, gain_code_low};
    s_d.diff = differential_mode;
    if (start_evt && !s_q.acq && sync_frame_counter_on_start) begin
      s_d.fcnt = RST_WORD;
    end
    // spacing runs from each start, so the conversion time lies inside it
    if (s_q.st == AIQ_CONVERT || s_q.st == AIQ_GAP) begin
      s_d.gap = (s_q.gap > {1'b0, TICKS_PER_CLK}) ? s_q.gap - {1'b0, TICKS_PER_CLK}
              : 33'h0_0000_0000;
    end
    case (s_q.st)
      AIQ_IDLE: begin
        s_d.acq = 1'b0;
        if (trigger_start_source == TRG_NONE) begin
          // no trigger configured: acquire freely
          s_d.acq = 1'b1;
          s_d.st = AIQ_WAIT_EVT;
        end else if (start_evt) begin
          s_d.acq = 1'b1;
          s_d.dly = trigger_delay_cycles;
          s_d.st = (trigger_delay_cycles != RST_WORD) ? AIQ_DELAY : AIQ_WAIT_EVT;
        end
      end
      AIQ_DELAY: begin
        s_d.dly = s_q.dly - 32'h0000_0001;
        if (s_q.dly <= 32'h0000_0001) begin
          s_d.st = AIQ_WAIT_EVT;
        end
      end
      AIQ_WAIT_EVT: begin
        if (stop_evt && trigger_start_source != TRG_NONE) begin
          s_d.st = AIQ_IDLE;
          s_d.acq = 1'b0;
        end else if (sample_evt && gate_ok) begin
          // events are only taken here, so a mid-scan event is dropped
          s_d.ch = (burst_mode || s_q.ch < first_channel || s_q.ch > last_channel)
                 ? first_channel : s_q.ch;
          s_d.gap = spacing_ticks;
          s_d.st = AIQ_CONVERT;
          s_d.cstart = 1'b1;
        end
      end
      AIQ_CONVERT: begin
        if (conv_done) begin
          // unipolar-off zero difference lands on midscale in straight binary
          s_d.sval = 1'b1;
          s_d.sdat = conv_data;
          s_d.sch = s_q.ch;
          if (last_in_scan) begin
            s_d.fdone = 1'b1;
            s_d.fcnt = s_q.fcnt + 32'h0000_0001;
            s_d.st = AIQ_WAIT_EVT;
            if (!burst_mode) begin
              // simple mode steps to next channel per event
              s_d.ch = (s_q.ch >= last_channel || s_q.ch >= ch_limit) ? first_channel
                     : s_q.ch + CH_W'(1);
            end
          end else begin
            // wait out the rest of the spacing; a slow converter starts next at once
            s_d.st = AIQ_GAP;
          end
        end
      end
      AIQ_GAP: begin
        // one clock or less of spacing left: the next start lands on time
        if (s_q.gap <= {1'b0, TICKS_PER_CLK}) begin
          s_d.ch = s_q.ch + CH_W'(1);
          s_d.gap = spacing_ticks;
          s_d.cstart = 1'b1;
          s_d.st = AIQ_CONVERT;
        end
      end
      default: s_d.st = AIQ_IDLE;
    endcase
    // selects change with the start pulse, so the converter sees the right pair
    if (s_d.cstart) begin
      s_d.mux_h = s_d.ch;
      s_d.mux_l = s_d.ch + CH_W'(NUM_DIFF_CH);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign mux_high_sel = s_q.mux_h;
  assign mux_low_sel = s_q.mux_l;
  assign mux_diff_en = s_q.diff;
  assign pga_gain = s_q.gain;
  assign pga_unipolar = s_q.unip;
  assign conv_start = s_q.cstart;
  assign sample_valid = s_q.sval;
  assign sample_data = s_q.sdat;
  assign sample_channel = s_q.sch;
  assign acquiring = s_q.acq;
  assign frame_done = s_q.fdone;
  assign frame_count = s_q.fcnt;
  assign range_code_out = s_q.range;
endmodule : aiq_sequencer
`default_nettype wire

// >>> test/aiq_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module aiq_seq_props #(
  parameter int CH_W = 4,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire aiq_pkg::aiq_mode_t acq_mode,
  input wire logic unipolar_select,
  input wire logic gain_code_high,
  input wire logic gain_code_low,
  input wire logic [CH_W-1:0] first_channel,
  input wire logic [CH_W-1:0] last_channel,
  input wire logic [31:0] burst_timer_ticks,
  input wire logic [31:0] frame_max,
  input wire logic conv_done,
  input wire logic [DATA_W-1:0] conv_data,
  input wire logic [CH_W-1:0] mux_high_sel,
  input wire logic [CH_W-1:0] mux_low_sel,
  input wire logic mux_diff_en,
  input wire logic [1:0] pga_gain,
  input wire logic pga_unipolar,
  input wire logic conv_start,
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] sample_data,
  input wire logic frame_done,
  input wire logic [31:0] frame_count
);
  import aiq_pkg::*;
  localparam int GAP = CLASSIC_GAP_NS / CLK_PERIOD_NS;
  logic [31:0] gap_q;
  logic in_scan_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // cycles since the last start; in_scan_q marks starts inside one scan
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 32'h0000_0000;
      in_scan_q <= 1'b0;
    end else begin
      gap_q <= conv_start ? 32'h0000_0001 : gap_q + 32'h0000_0001;
      in_scan_q <= conv_start | (in_scan_q & ~frame_done);
    end
  end
  property p_range;
    $past(rst_n) |-> pga_gain == $past({gain_code_high, gain_code_low})
      && pga_unipolar == $past(unipolar_select);
  endproperty
  a_range: assert property (p_range) else $error("range select wrong");
  property p_diff;
    conv_start && mux_diff_en |-> mux_low_sel == mux_high_sel + 4'h8 && !mux_high_sel[3];
  endproperty
  a_diff: assert property (p_diff) else $error("pair select wrong");
  property p_data;
    conv_done |=> sample_valid && sample_data == $past(conv_data);
  endproperty
  a_data: assert property (p_data) else $error("sample not stored");
  property p_cause;
    sample_valid |-> $past(conv_done);
  endproperty
  a_cause: assert property (p_cause) else $error("sample without conversion");
  property p_pulse;
    conv_start |=> !conv_start [*3];
  endproperty
  a_pulse: assert property (p_pulse) else $error("start too close");
  property p_bounds;
    conv_start |-> mux_high_sel >= first_channel && mux_high_sel <= last_channel;
  endproperty
  a_bounds: assert property (p_bounds) else $error("channel out of scan");
  property p_classic;
    conv_start && acq_mode == AIQ_MODE_CLASSIC_BURST && mux_high_sel != last_channel
      |-> ##GAP conv_start;
  endproperty
  a_classic: assert property (p_classic) else $error("classic spacing wrong");
  // fraction-free spacing only: ticks beyond the base must be a multiple of four
  property p_burst;
    conv_start && in_scan_q && acq_mode == AIQ_MODE_BURST
      |-> gap_q * TICKS_PER_CLK == BURST_BASE_TICKS + burst_timer_ticks;
  endproperty
  a_burst: assert property (p_burst) else $error("burst spacing wrong");
  property p_nmax;
    acq_mode == AIQ_MODE_NSAMPLE && frame_max != 0 && frame_count >= frame_max |-> !conv_start;
  endproperty
  a_nmax: assert property (p_nmax) else $error("sampling past maximum");
  c_diff: cover property (conv_start && mux_diff_en);
  c_burst: cover property (conv_start && in_scan_q && acq_mode == AIQ_MODE_BURST);
  c_nsamp: cover property (frame_done && acq_mode == AIQ_MODE_NSAMPLE);
endmodule : aiq_seq_props
bind aiq_sequencer aiq_seq_props #(.CH_W(CH_W), .DATA_W(DATA_W)) u_props (.*);
`default_nettype wire

// >>> test/aiq_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module aiq_conv_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_start,
  input wire logic [3:0] mux_high_sel,
  output logic conv_done,
  output logic [15:0] conv_data
);
  logic [3:0] ch;
  // converter with random latency; data tagged with the selected channel
  initial begin
    conv_done = 1'b0;
    conv_data = 16'h0000;
    forever begin
      @(posedge clk);
      if (rst_n === 1'b1 && conv_start === 1'b1) begin
        ch = mux_high_sel;
        repeat ($urandom_range(1, 30)) @(posedge clk);
        conv_done <= 1'b1;
        conv_data <= {ch, 12'($urandom)};
        @(posedge clk);
        conv_done <= 1'b0;
        conv_data <= ~conv_data; // stale word never looks valid
      end
    end
  end
endmodule : aiq_conv_model
`default_nettype wire

// >>> test/tb_aiq_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_aiq_sequencer;
  import aiq_pkg::*;
  logic clk, rst_n, unipolar_select, gain_code_high, gain_code_low, differential_mode;
  logic sample_gate_control, ext_gate_pin, software_strobe, software_trigger;
  logic sync_frame_timer_on_start, sync_frame_counter_on_start, conv_done;
  logic mux_diff_en, pga_unipolar, conv_start, sample_valid, acquiring, frame_done;
  logic [3:0] first_channel, last_channel, sample_event_select, trigger_start_source;
  logic [3:0] mux_high_sel, mux_low_sel, sample_channel, exp_ch, p;
  logic [12:0] sample_event_sources;
  logic [1:0] sample_source_select, pga_gain, range_code_out;
  logic [31:0] burst_timer_ticks, frame_max, trigger_delay_cycles, frame_count;
  logic [15:0] conv_data, sample_data;
  aiq_mode_t acq_mode;
  logic [3:0] q[$];
  int errors = 0;
  int n_checks = 0;
  aiq_sequencer DUT (.clk(clk), .rst_n(rst_n), .acq_mode(acq_mode),
    .unipolar_select(unipolar_select), .gain_code_high(gain_code_high),
    .gain_code_low(gain_code_low), .differential_mode(differential_mode),
    .first_channel(first_channel), .last_channel(last_channel),
    .sample_event_select(sample_event_select), .sample_event_sources(sample_event_sources),
    .sample_gate_control(sample_gate_control), .sample_source_select(sample_source_select),
    .ext_gate_pin(ext_gate_pin), .software_strobe(software_strobe), .frame_sync_pin(1'b0),
    .frame_timer_ticks(32'h0000_1000), .burst_timer_ticks(burst_timer_ticks),
    .frame_max(frame_max), .trigger_delay_cycles(trigger_delay_cycles),
    .trigger_start_source(trigger_start_source), .trigger_stop_source(TRG_NONE),
    .ext_trigger_pin(1'b0), .software_trigger(software_trigger),
    .sync_frame_timer_on_start(sync_frame_timer_on_start),
    .sync_frame_counter_on_start(sync_frame_counter_on_start), .conv_done(conv_done),
    .conv_data(conv_data), .mux_high_sel(mux_high_sel), .mux_low_sel(mux_low_sel),
    .mux_diff_en(mux_diff_en), .pga_gain(pga_gain), .pga_unipolar(pga_unipolar),
    .conv_start(conv_start), .sample_valid(sample_valid), .sample_data(sample_data),
    .sample_channel(sample_channel), .acquiring(acquiring), .frame_done(frame_done),
    .frame_count(frame_count), .range_code_out(range_code_out));
  aiq_conv_model u_conv (.clk(clk), .rst_n(rst_n), .conv_start(conv_start),
    .mux_high_sel(mux_high_sel), .conv_done(conv_done), .conv_data(conv_data));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one-cycle event on the chosen source
  task automatic fire(input logic [3:0] s);
    @(posedge clk);
    if (s == SRC_SOFTWARE) software_strobe <= 1'b1;
    else sample_event_sources <= 13'h0001 << s;
    @(posedge clk);
    software_strobe <= 1'b0;
    sample_event_sources <= 13'h0000;
  endtask : fire
  task automatic scan(input int f, input int l);
    for (int c = f; c <= l; c++) q.push_back(4'(c));
  endtask : scan
  // bounded wait for outstanding samples, then idle past any gap
  task automatic drain;
    for (int k = 0; k < 3000 && q.size() > 0; k++) @(posedge clk);
    tick(60);
  endtask : drain
  // results in order against the oldest note
  always @(posedge clk) begin
    if (sample_valid === 1'b1) begin
      if (q.size() == 0) chk(32'h1, 32'h0);
      else begin
        exp_ch = q.pop_front();
        chk(32'(sample_channel), 32'(exp_ch));
        chk(32'(sample_data[15:12]), 32'(exp_ch));
      end
    end
  end
  initial begin
    tick(40000);
    errors++;
    conclude();
  end
  initial begin
    {rst_n, unipolar_select, gain_code_high, gain_code_low, differential_mode} = 5'h00;
    {sample_gate_control, ext_gate_pin, software_strobe, software_trigger} = 4'h0;
    {sync_frame_timer_on_start, sync_frame_counter_on_start} = 2'h0;
    acq_mode = AIQ_MODE_SIMPLE;
    first_channel = 4'h3;
    last_channel = 4'h5;
    sample_event_select = SRC_SOFTWARE;
    trigger_start_source = TRG_NONE;
    sample_event_sources = 13'h0000;
    sample_source_select = 2'h0;
    burst_timer_ticks = 32'h0000_0000;
    frame_max = 32'h0000_0000;
    trigger_delay_cycles = 32'h0000_0000;
    void'($urandom(47404));
    tick(20);
    rst_n <= 1'b1;
    tick(2);
    for (int i = 0; i < 8; i++) begin
      {unipolar_select, gain_code_high, gain_code_low} <= 3'(i);
      tick(2);
      chk(32'({pga_unipolar, pga_gain}), 32'(i));
      chk(32'(range_code_out), 32'(i[1:0]));
    end
    // simple mode: software strobe then each extra source, channel wraps at last
    p = 4'h3;
    for (int i = 0; i < 14; i++) begin
      sample_event_select <= (i < 4) ? SRC_SOFTWARE : 4'(i - 1);
      tick(2 + $urandom_range(0, 20));
      q.push_back(p);
      p = (p == 4'h5) ? 4'h3 : p + 4'h1;
      fire(sample_event_select);
      drain();
    end
    // classic burst, differential pairs; a strobe mid-scan is dropped
    sample_event_select <= SRC_SOFTWARE;
    acq_mode <= AIQ_MODE_CLASSIC_BURST;
    {differential_mode, first_channel, last_channel} <= 9'h102;
    tick(4);
    scan(0, 2);
    fire(SRC_SOFTWARE);
    tick(10);
    fire(SRC_SOFTWARE);
    drain();
    // burst timer spacing, then gate blocks and gate pin admits
    acq_mode <= AIQ_MODE_BURST;
    {differential_mode, first_channel, last_channel} <= 9'h014;
    burst_timer_ticks <= 32'h0000_0008;
    tick(4);
    scan(1, 4);
    fire(SRC_SOFTWARE);
    drain();
    sample_gate_control <= 1'b1;
    sample_source_select <= 2'h3;
    tick(4);
    fire(SRC_SOFTWARE);
    drain();
    sample_source_select <= 2'h1;
    ext_gate_pin <= 1'b1;
    tick(4);
    scan(1, 4);
    fire(SRC_SOFTWARE);
    drain();
    // n-sample: start trigger, delay drops an early event, stop at maximum
    acq_mode <= AIQ_MODE_NSAMPLE;
    {sample_gate_control, first_channel, last_channel} <= 9'h000;
    {frame_max, trigger_delay_cycles} <= {32'h0000_0002, 32'h0000_0005};
    trigger_start_source <= TRG_SOFTWARE;
    {sync_frame_timer_on_start, sync_frame_counter_on_start} <= 2'h3;
    tick(4);
    software_trigger <= 1'b1;
    tick(1);
    software_trigger <= 1'b0;
    fire(SRC_SOFTWARE);
    tick(10);
    scan(0, 0);
    scan(0, 0);
    repeat (4) begin
      fire(SRC_SOFTWARE);
      tick(80);
    end
    drain();
    chk(frame_count, 32'h0000_0002);
    chk(32'(q.size()), 32'h0);
    chk(32'(acquiring), 32'h0);
    conclude();
  end
endmodule : tb_aiq_sequencer
`default_nettype wire
